/* sgp_port.sv */
// Seven-pin general-purpose port with Wishbone register access
//
// Chosen here: register access over Wishbone and the address map.
`timescale 1ns/100ps
`default_nettype none
module sgp_port (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [2:0] OPERATING_MODE,
    input wire logic EXTERNAL_EXPANSION_ENABLE,
    input wire logic [3:0] CHIP_SELECT_ENABLE_BITS,
    input wire logic [3:0] CHIP_SELECT_VALUE,
    input wire logic [2:0] BUS_CONTROL_ENABLE,
    input wire logic BUS_REQUEST_OUT,
    input wire logic BUS_ACK_OUT,
    output logic BUS_REQUEST_IN,
    input wire logic [6:0] PIN_I,
    output logic [6:0] PIN_O,
    output logic [6:0] PIN_OE_N
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [6:0] direction;
        logic [6:0] output_value;
        logic [6:0] open_drain;
        logic ack;
        logic [31:0] rdata;
        logic [6:0] pin_o;
        logic [6:0] pin_oe_n;
        logic bus_req_in;
    } sgp_state_s;

    sgp_state_s st;
    sgp_state_s next_st;
    logic [6:0] pin_level;
    logic expanded;
    logic [6:0] alt_en;
    logic [6:0] alt_drive;
    logic [6:0] alt_val;
    logic req;
    logic [6:0] od_mask;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic is_expanded(input logic [2:0] mode,
                                         input logic exp_en);
        is_expanded = (mode == sgp_pkg::MODE_1)
                   || (mode == sgp_pkg::MODE_2)
                   || (mode == sgp_pkg::MODE_4)
                   || ((mode == sgp_pkg::MODE_7) && exp_en);
    endfunction

    function automatic logic [6:0] level_of(input logic [6:0] dir,
                                            input logic [6:0] outv,
                                            input logic [6:0] pins);
        level_of = (dir & outv) | (~dir & pins);
    endfunction

    function automatic logic pin0_resets_out(input logic [2:0] mode);
        pin0_resets_out = (mode == sgp_pkg::MODE_1)
                       || (mode == sgp_pkg::MODE_2);
    endfunction

    // ----------------------------------------
    // Pin input synchroniser
    // ----------------------------------------
    sgp_sync u_sync (
        .CLOCK(CLOCK),
        .SYS_RST(SYS_RST),
        .async_in(PIN_I),
        .sync_out(pin_level)
    );

    // ----------------------------------------
    // Pin function selection
    // ----------------------------------------
    assign expanded = is_expanded(OPERATING_MODE,
                                  EXTERNAL_EXPANSION_ENABLE);
    assign alt_en = {BUS_CONTROL_ENABLE & {3{expanded}},
                     CHIP_SELECT_ENABLE_BITS & {4{expanded}}};
    assign alt_drive = {1'b0, 1'b1, 1'b1,
                        st.direction[sgp_pkg::CS_HI:sgp_pkg::CS_LO]};
    assign alt_val = {1'b0, BUS_ACK_OUT, BUS_REQUEST_OUT,
                      CHIP_SELECT_VALUE};
    assign req = WB_CYC_I && WB_STB_I;
    assign od_mask = ~alt_en & st.direction & st.open_drain;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.ack = 1'b0;
        if (req && !st.ack) begin
            next_st.ack = 1'b1;
            next_st.rdata = sgp_pkg::READ_ZERO;
            if (WB_ADR_I == sgp_pkg::ADR_DIRECTION) begin
                if (WB_WE_I && WB_SEL_I[sgp_pkg::LANE0]) begin
                    next_st.direction = WB_DAT_I[6:0];
                end
            end else if (WB_ADR_I == sgp_pkg::ADR_OUTPUT_VALUE) begin
                if (WB_WE_I && WB_SEL_I[sgp_pkg::LANE0]) begin
                    next_st.output_value = WB_DAT_I[6:0];
                end
                next_st.rdata[6:0] = st.output_value;
            end else if (WB_ADR_I == sgp_pkg::ADR_LEVEL) begin
                next_st.rdata[6:0] = level_of(st.direction,
                                              st.output_value,
                                              pin_level);
            end else if (WB_ADR_I == sgp_pkg::ADR_OPEN_DRAIN) begin
                if (WB_WE_I && WB_SEL_I[sgp_pkg::LANE0]) begin
                    next_st.open_drain = WB_DAT_I[6:0];
                end
                next_st.rdata[6:0] = st.open_drain;
            end
        end
        for (int i = 0; i < sgp_pkg::PINS; i++) begin
            if (alt_en[i]) begin
                next_st.pin_o[i] = alt_val[i];
                next_st.pin_oe_n[i] = ~alt_drive[i];
            end else if (st.direction[i]) begin
                if (st.open_drain[i]) begin
                    next_st.pin_o[i] = 1'b0;
                    next_st.pin_oe_n[i] = st.output_value[i];
                end else begin
                    next_st.pin_o[i] = st.output_value[i];
                    next_st.pin_oe_n[i] = 1'b0;
                end
            end else begin
                next_st.pin_o[i] = 1'b0;
                next_st.pin_oe_n[i] = 1'b1;
            end
        end
        next_st.bus_req_in = alt_en[sgp_pkg::PIN_BUS_REQ_IN]
                          && pin_level[sgp_pkg::PIN_BUS_REQ_IN];
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            st <= '0;
            st.direction <= sgp_pkg::RST_DIRECTION;
            st.direction[sgp_pkg::PIN0] <=
                pin0_resets_out(OPERATING_MODE);
            st.output_value <= sgp_pkg::RST_OUTPUT_VALUE;
            st.open_drain <= sgp_pkg::RST_OPEN_DRAIN;
            st.pin_oe_n <= sgp_pkg::RST_PIN_OE_N;
        end else begin
            st <= next_st;
        end
    end

    assign WB_DAT_O = st.rdata;
    assign WB_ACK_O = st.ack;
    assign PIN_O = st.pin_o;
    assign PIN_OE_N = st.pin_oe_n;
    assign BUS_REQUEST_IN = st.bus_req_in;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_ACK_SINGLE: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");

    AST_ACK_AFTER_REQ: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        (req && !st.ack) |=> WB_ACK_O)
        else $error("request not acknowledged in one cycle");

    AST_DIR_WRITE: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        (req && !st.ack && WB_WE_I && WB_SEL_I[sgp_pkg::LANE0]
         && WB_ADR_I == sgp_pkg::ADR_DIRECTION)
        |=> st.direction == $past(WB_DAT_I[6:0]) && WB_ACK_O)
        else $error("direction write not stored");

    AST_DIR_READ_ZERO: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        (req && !st.ack && !WB_WE_I && WB_ADR_I == sgp_pkg::ADR_DIRECTION)
        |=> WB_DAT_O == sgp_pkg::READ_ZERO)
        else $error("direction read not zero");

    AST_PIN0_RESET: assert property (@(posedge CLOCK)
        SYS_RST |=> st.direction[0] == pin0_resets_out($past(OPERATING_MODE))
                    && st.direction[6:1] == 6'h00)
        else $error("direction reset value wrong");

    AST_BUS_REQ_OUT: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        (expanded && BUS_CONTROL_ENABLE[0])
        |=> PIN_O[sgp_pkg::PIN_BUS_REQ_OUT] == $past(BUS_REQUEST_OUT)
            && !PIN_OE_N[sgp_pkg::PIN_BUS_REQ_OUT])
        else $error("bus request output not routed");

    AST_BUS_ACK_OUT: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        (expanded && BUS_CONTROL_ENABLE[1])
        |=> PIN_O[sgp_pkg::PIN_BUS_ACK_OUT] == $past(BUS_ACK_OUT)
            && !PIN_OE_N[sgp_pkg::PIN_BUS_ACK_OUT])
        else $error("bus acknowledge output not routed");

    AST_BUS_REQ_IN: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        (expanded && BUS_CONTROL_ENABLE[2])
        |=> PIN_OE_N[sgp_pkg::PIN_BUS_REQ_IN]
            && BUS_REQUEST_IN == $past(pin_level[sgp_pkg::PIN_BUS_REQ_IN]))
        else $error("bus request input not routed");

    AST_BUS_REQ_IDLE: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        !alt_en[sgp_pkg::PIN_BUS_REQ_IN] |=> !BUS_REQUEST_IN)
        else $error("bus request input active while not selected");

    AST_CS_DRIVE: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        (expanded && CHIP_SELECT_ENABLE_BITS[1])
        |=> PIN_OE_N[1] == !$past(st.direction[1])
            && (!$past(st.direction[1])
                || PIN_O[1] == $past(CHIP_SELECT_VALUE[1])))
        else $error("chip-select pin function wrong");

    AST_CS_OFF_PLAIN: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        (expanded && !CHIP_SELECT_ENABLE_BITS[2] && !st.open_drain[2])
        |=> PIN_OE_N[2] == !$past(st.direction[2]))
        else $error("chip-select disabled pin not plain");

    AST_PLAIN_MODE7: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        (OPERATING_MODE == sgp_pkg::MODE_7 && !EXTERNAL_EXPANSION_ENABLE
         && st.direction[5] && !st.open_drain[5])
        |=> PIN_O[5] == $past(st.output_value[5]) && !PIN_OE_N[5])
        else $error("plain output in mode 7 wrong");

    AST_OUT_WRITE: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        (req && !st.ack && WB_WE_I && WB_SEL_I[sgp_pkg::LANE0]
         && WB_ADR_I == sgp_pkg::ADR_OUTPUT_VALUE)
        |=> st.output_value == $past(WB_DAT_I[6:0]))
        else $error("output value write not stored");

    AST_OUT_BIT7: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        (req && !st.ack && !WB_WE_I && WB_ADR_I == sgp_pkg::ADR_OUTPUT_VALUE)
        |=> WB_DAT_O[7:0] == {1'b0, $past(st.output_value)})
        else $error("output value readback wrong");

    AST_LEVEL_READ: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        (req && !st.ack && !WB_WE_I && WB_ADR_I == sgp_pkg::ADR_LEVEL)
        |=> WB_DAT_O[6:0] == level_of($past(st.direction),
                                      $past(st.output_value),
                                      $past(pin_level)))
        else $error("level readback wrong");

    AST_LEVEL_NO_WRITE: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        (req && !st.ack && WB_WE_I && WB_ADR_I == sgp_pkg::ADR_LEVEL)
        |=> $stable(st.direction) && $stable(st.output_value)
            && $stable(st.open_drain))
        else $error("level register write changed state");

    AST_OPEN_DRAIN: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        (|od_mask)
        |=> (PIN_O & $past(od_mask)) == '0
            && (PIN_OE_N & $past(od_mask))
               == ($past(st.output_value) & $past(od_mask)))
        else $error("open-drain drive wrong");

    AST_OD_READ: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        (req && !st.ack && !WB_WE_I && WB_ADR_I == sgp_pkg::ADR_OPEN_DRAIN)
        |=> WB_DAT_O == {25'h0000000, $past(st.open_drain)})
        else $error("open-drain readback wrong");

    AST_INPUT_RELEASE: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        (!alt_en[3] && !st.direction[3])
        |=> PIN_OE_N[3] && !PIN_O[3])
        else $error("input pin still driven");

endmodule
`default_nettype wire

/* sgp_pkg.sv */
// Constants and register map of the seven-pin general-purpose port
package sgp_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int PINS = 7;
    localparam int ADR_W = 4;
    localparam int DAT_W = 32;
    localparam int REG_W = 8;

    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [3:0] ADR_DIRECTION = 4'h0;
    localparam logic [3:0] ADR_OUTPUT_VALUE = 4'h4;
    localparam logic [3:0] ADR_LEVEL = 4'h8;
    localparam logic [3:0] ADR_OPEN_DRAIN = 4'hC;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [6:0] RST_DIRECTION = 7'h00;
    localparam logic [6:0] RST_OUTPUT_VALUE = 7'h00;
    localparam logic [6:0] RST_OPEN_DRAIN = 7'h00;
    localparam logic [6:0] RST_PIN_OE_N = 7'h7F;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int PIN0 = 0;
    localparam int PIN_BUS_REQ_OUT = 4;
    localparam int PIN_BUS_ACK_OUT = 5;
    localparam int PIN_BUS_REQ_IN = 6;
    localparam int CS_LO = 0;
    localparam int CS_HI = 3;
    localparam int LANE0 = 0;

    // ----------------------------------------
    // Operating modes
    // ----------------------------------------
    typedef enum logic [2:0] {
        MODE_1 = 3'h1,
        MODE_2 = 3'h2,
        MODE_4 = 3'h4,
        MODE_7 = 3'h7
    } sgp_mode_e;

endpackage

/* sgp_sync.sv */
// Two-stage synchroniser for the port pin inputs
`timescale 1ns/100ps
`default_nettype none
module sgp_sync (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic [6:0] async_in,
    output logic [6:0] sync_out
);

    typedef struct packed {
        logic [6:0] stage1;
        logic [6:0] stage2;
    } sgp_sync_s;

    sgp_sync_s st;
    sgp_sync_s next_st;

    always_comb begin
        next_st.stage1 = async_in;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.stage2;

endmodule
`default_nettype wire

/* sgp_board.sv */
// Board model that closes the seven port pins
`timescale 1ns/100ps
`default_nettype none
module sgp_board (
    input wire logic [6:0] PIN_O,
    input wire logic [6:0] PIN_OE_N,
    input wire logic [6:0] EXT_VAL,
    input wire logic [6:0] EXT_EN,
    output logic [6:0] PIN_I
);
    // --------------------------------
    // Pin level resolution
    // --------------------------------
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            if (!PIN_OE_N[i]) begin
                PIN_I[i] = PIN_O[i];
            end else if (EXT_EN[i]) begin
                PIN_I[i] = EXT_VAL[i];
            end else begin
                PIN_I[i] = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench of the seven-pin port
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] rq;
    logic ack;
    logic [2:0] mode = 3'h1;
    logic exp_en = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [3:0] cse = 4'h0;
    logic [3:0] csv = 4'h0;
    logic [2:0] bce = 3'h0;
    logic bro = 1'b0;
    logic bao = 1'b0;
    logic bri;
    logic [6:0] pin_i;
    logic [6:0] pin_o;
    logic [6:0] oe;
    logic [6:0] ext_val = 7'h00;
    logic [6:0] ext_en = 7'h00;
    int mismatches = 0;
    int n_tests = 0;

    always #2.5 clk = ~clk;

    sgp_port DUT (.CLOCK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .OPERATING_MODE(mode),
        .EXTERNAL_EXPANSION_ENABLE(exp_en), .CHIP_SELECT_ENABLE_BITS(cse),
        .CHIP_SELECT_VALUE(csv), .BUS_CONTROL_ENABLE(bce),
        .BUS_REQUEST_OUT(bro), .BUS_ACK_OUT(bao), .BUS_REQUEST_IN(bri),
        .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_N(oe));
    sgp_board board (.PIN_O(pin_o), .PIN_OE_N(oe), .EXT_VAL(ext_val),
        .EXT_EN(ext_en), .PIN_I(pin_i));

    // --------------------------------
    // Bus and timing helpers
    // --------------------------------
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wd <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rq = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        wb(1'b1, a, 4'hF, {24'h000000, d});
    endtask
    task automatic rd(input logic [3:0] a);
        wb(1'b0, a, 4'hF, 32'h0000_0000);
    endtask

    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic reset_in(input logic [2:0] m, input logic [6:0] e);
        mode <= m;
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        wait_clk(3);
        `CHK(oe, e)
    endtask
    task automatic t_reset;
        wait_clk(3);
        `CHK(oe, 7'h7E)
        rd(sgp_pkg::ADR_OUTPUT_VALUE);
        `CHK(rq, 32'h0000_0000)
        rd(sgp_pkg::ADR_DIRECTION);
        `CHK(rq, 32'h0000_0000)
        rd(sgp_pkg::ADR_OPEN_DRAIN);
        `CHK(rq, 32'h0000_0000)
        reset_in(sgp_pkg::MODE_4, 7'h7F);
        reset_in(sgp_pkg::MODE_2, 7'h7E);
        reset_in(sgp_pkg::MODE_7, 7'h7F);
    endtask
    task automatic t_regs;
        wr(sgp_pkg::ADR_OUTPUT_VALUE, 8'hFF);
        wr(sgp_pkg::ADR_DIRECTION, 8'h7F);
        rd(sgp_pkg::ADR_OUTPUT_VALUE);
        `CHK(rq, 32'h0000_007F)
        wb(1'b1, sgp_pkg::ADR_OUTPUT_VALUE, 4'hE, 32'h0000_0000);
        rd(sgp_pkg::ADR_OUTPUT_VALUE);
        `CHK(rq, 32'h0000_007F)
        wait_clk(2);
        `CHK(pin_o, 7'h7F)
        `CHK(oe, 7'h00)
    endtask
    task automatic t_level;
        wr(sgp_pkg::ADR_OUTPUT_VALUE, 8'h05);
        wr(sgp_pkg::ADR_DIRECTION, 8'h0F);
        ext_en <= 7'h70;
        ext_val <= 7'h50;
        wr(sgp_pkg::ADR_LEVEL, 8'h7F);
        wait_clk(4);
        rd(sgp_pkg::ADR_LEVEL);
        `CHK(rq, 32'h0000_0055)
        rd(4'h1);
        `CHK(rq, 32'h0000_0000)
    endtask
    task automatic t_od;
        wr(sgp_pkg::ADR_OPEN_DRAIN, 8'h01);
        wr(sgp_pkg::ADR_OUTPUT_VALUE, 8'h01);
        rd(sgp_pkg::ADR_OPEN_DRAIN);
        `CHK(rq, 32'h0000_0001)
        `CHK(oe[0], 1'b1)
        wr(sgp_pkg::ADR_OUTPUT_VALUE, 8'h00);
        wait_clk(2);
        `CHK({oe[0], pin_o[0]}, 2'b00)
        wr(sgp_pkg::ADR_OPEN_DRAIN, 8'h00);
    endtask
    task automatic t_cs;
        exp_en <= 1'b1;
        cse <= 4'hF;
        csv <= 4'hA;
        wait_clk(2);
        `CHK(pin_o[3:0], 4'hA)
        `CHK(oe[3:0], 4'h0)
        wr(sgp_pkg::ADR_DIRECTION, 8'h0C);
        wait_clk(2);
        `CHK(oe[3:0], 4'h3)
        cse <= 4'h0;
        wait_clk(2);
        `CHK({pin_o[3:2], oe[3:0]}, 6'h03)
    endtask
    task automatic t_bus;
        wr(sgp_pkg::ADR_DIRECTION, 8'h00);
        bce <= 3'h7;
        bro <= 1'b1;
        ext_en <= 7'h40;
        ext_val <= 7'h40;
        wait_clk(4);
        `CHK({oe[6:4], pin_o[5:4]}, 5'b10001)
        `CHK(bri, 1'b1)
        bro <= 1'b0;
        bao <= 1'b1;
        wait_clk(2);
        `CHK(pin_o[5:4], 2'b10)
        exp_en <= 1'b0;
        wait_clk(4);
        `CHK(oe[6:4], 3'b111)
        `CHK(bri, 1'b0)
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #20000;
        mismatches++;
        finish_test();
    end

    initial begin
        wait_clk(3);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_level();
        t_od();
        t_cs();
        t_bus();
        finish_test();
    end
endmodule
`default_nettype wire
